// ==== lfx_pkg.sv ====
// Package for the left-channel effects coefficient register bank.
// Assumes an 8-bit register port on the second register page.
package lfx_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned COEF_W = 16;

    // Page holding the effects coefficients
    localparam logic [7:0] COEF_PAGE = 8'h01;

    // Register addresses on that page
    localparam logic [ADDR_W-1:0] LEFT_FX_NUM5_HIGH = 7'h0b;
    localparam logic [ADDR_W-1:0] LEFT_FX_NUM5_LOW = 7'h0c;
    localparam logic [ADDR_W-1:0] LEFT_FX_DEN1_HIGH = 7'h0d;
    localparam logic [ADDR_W-1:0] LEFT_FX_DEN1_LOW = 7'h0e;
    localparam logic [ADDR_W-1:0] LEFT_FX_DEN2_HIGH = 7'h0f;
    localparam logic [ADDR_W-1:0] LEFT_FX_DEN2_LOW = 7'h10;
    localparam logic [ADDR_W-1:0] LEFT_FX_DEN4_HIGH = 7'h11;
    localparam logic [ADDR_W-1:0] LEFT_FX_DEN4_LOW = 7'h12;
    localparam logic [ADDR_W-1:0] LEFT_FX_DEN5_HIGH = 7'h13;
    localparam logic [ADDR_W-1:0] LEFT_FX_DEN5_LOW = 7'h14;

    // Reset values
    localparam logic [DATA_W-1:0] NUM5_HIGH_RST = 8'h67;
    localparam logic [DATA_W-1:0] NUM5_LOW_RST = 8'h5d;
    localparam logic [DATA_W-1:0] DEN1_HIGH_RST = 8'h7d;
    localparam logic [DATA_W-1:0] DEN1_LOW_RST = 8'h83;
    localparam logic [DATA_W-1:0] DEN2_HIGH_RST = 8'h84;
    localparam logic [DATA_W-1:0] DEN2_LOW_RST = 8'hee;
    localparam logic [DATA_W-1:0] DEN4_HIGH_RST = 8'h7d;
    localparam logic [DATA_W-1:0] DEN4_LOW_RST = 8'h83;
    localparam logic [DATA_W-1:0] DEN5_HIGH_RST = 8'h84;
    localparam logic [DATA_W-1:0] DEN5_LOW_RST = 8'hee;

    // Value read back from addresses this bank does not own
    localparam logic [DATA_W-1:0] UNMAPPED_RD = 8'h00;
endpackage

// ==== lfx_coef_pair.sv ====
// One 16-bit coefficient held as a high and a low 8-bit register.
// Assumes single-cycle write strobes from the bank decoder.
`timescale 1ns/1ps
`default_nettype none
module lfx_coef_pair #(
    parameter logic [7:0] HIGH_RST = 8'h00,
    parameter logic [7:0] LOW_RST = 8'h00
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_high_i,
    input wire logic wr_low_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] high_o,
    output logic [7:0] low_o,
    output logic signed [15:0] coef_o
);
    logic [7:0] high_q;
    logic [7:0] low_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            high_q <= HIGH_RST;
        end else if (wr_high_i) begin
            high_q <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_q <= LOW_RST;
        end else if (wr_low_i) begin
            low_q <= wdata_i;
        end
    end

    assign high_o = high_q;
    assign low_o = low_q;
    // High byte above low byte, two's complement
    assign coef_o = signed'({high_q, low_q}); // R1 R9
endmodule
`default_nettype wire

// ==== lfx_coef_regs.sv ====
// Left-channel effects filter coefficient registers, second page.
// Assumes a simple synchronous register port from the control-bus
// decoder: page, address, write strobe, write data, read strobe.
//
// Functional notes
// R1: Pairs form signed 16-bit two's-complement coefficients.
// R2: Each register 8 bits, fully read/write.
// R3: Numerator five resets 0x67/0x5d, addresses 11-12.
// R4: Denominator one resets 0x7d/0x83, addresses 13-14.
// R5: Denominator two resets 0x84/0xee, addresses 15-16.
// R6: Denominator four resets 0x7d/0x83, addresses 17-18.
// R7: Denominator five high resets 0x84, address 19.
// R8: Denominator five low resets 0xee, address 20.
// R9: Coefficient output is high over low, last written.
`timescale 1ns/1ps
`default_nettype none
module lfx_coef_regs (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] page_i,
    input wire logic [lfx_pkg::ADDR_W-1:0] addr_i,
    input wire logic wr_en_i,
    input wire logic [lfx_pkg::DATA_W-1:0] wdata_i,
    input wire logic rd_en_i,
    output logic [lfx_pkg::DATA_W-1:0] rdata_o,
    output logic rvalid_o,
    output logic signed [lfx_pkg::COEF_W-1:0] effects_numerator_five_o,
    output logic signed [lfx_pkg::COEF_W-1:0] effects_denominator_one_o,
    output logic signed [lfx_pkg::COEF_W-1:0] effects_denominator_two_o,
    output logic signed [lfx_pkg::COEF_W-1:0] effects_denominator_four_o,
    output logic signed [lfx_pkg::COEF_W-1:0] effects_denominator_five_o
);
    localparam int unsigned NCOEF = 5;

    // Index order: num5, den1, den2, den4, den5
    localparam logic [lfx_pkg::ADDR_W-1:0] HIGH_ADDR [NCOEF] = '{
        lfx_pkg::LEFT_FX_NUM5_HIGH, lfx_pkg::LEFT_FX_DEN1_HIGH,
        lfx_pkg::LEFT_FX_DEN2_HIGH, lfx_pkg::LEFT_FX_DEN4_HIGH,
        lfx_pkg::LEFT_FX_DEN5_HIGH};
    localparam logic [lfx_pkg::ADDR_W-1:0] LOW_ADDR [NCOEF] = '{
        lfx_pkg::LEFT_FX_NUM5_LOW, lfx_pkg::LEFT_FX_DEN1_LOW,
        lfx_pkg::LEFT_FX_DEN2_LOW, lfx_pkg::LEFT_FX_DEN4_LOW,
        lfx_pkg::LEFT_FX_DEN5_LOW};
    localparam logic [7:0] HIGH_RST [NCOEF] = '{
        lfx_pkg::NUM5_HIGH_RST, lfx_pkg::DEN1_HIGH_RST,
        lfx_pkg::DEN2_HIGH_RST, lfx_pkg::DEN4_HIGH_RST,
        lfx_pkg::DEN5_HIGH_RST}; // R3 R4 R5 R6 R7
    localparam logic [7:0] LOW_RST [NCOEF] = '{
        lfx_pkg::NUM5_LOW_RST, lfx_pkg::DEN1_LOW_RST,
        lfx_pkg::DEN2_LOW_RST, lfx_pkg::DEN4_LOW_RST,
        lfx_pkg::DEN5_LOW_RST}; // R3 R4 R5 R6 R8

    // Access hits this page at the given address
    function automatic logic hit(input logic [7:0] page,
                                 input logic [lfx_pkg::ADDR_W-1:0] addr,
                                 input logic [lfx_pkg::ADDR_W-1:0] target);
        hit = (page == lfx_pkg::COEF_PAGE) && (addr == target);
    endfunction

    // High byte above low byte as one signed coefficient
    function automatic logic signed [15:0] coef_of(input logic [7:0] high,
                                                   input logic [7:0] low);
        coef_of = signed'({high, low}); // R1 R9
    endfunction

    logic [7:0] high_w [NCOEF];
    logic [7:0] low_w [NCOEF];
    logic signed [15:0] coef_w [NCOEF];
    logic [NCOEF-1:0] wr_high;
    logic [NCOEF-1:0] wr_low;

    // One write strobe per byte register
    for (genvar g = 0; g < NCOEF; g++) begin : g_strobe
        assign wr_high[g] = wr_en_i && hit(page_i, addr_i, HIGH_ADDR[g]); // R2
        assign wr_low[g] = wr_en_i && hit(page_i, addr_i, LOW_ADDR[g]); // R2
    end

    // Numerator five, registers 0x0b and 0x0c
    lfx_coef_pair #(
        .HIGH_RST(HIGH_RST[0]),
        .LOW_RST(LOW_RST[0])
    ) u_num5 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_high_i(wr_high[0]),
        .wr_low_i(wr_low[0]),
        .wdata_i(wdata_i),
        .high_o(high_w[0]),
        .low_o(low_w[0]),
        .coef_o(coef_w[0])
    );

    // Denominator one, registers 0x0d and 0x0e
    lfx_coef_pair #(
        .HIGH_RST(HIGH_RST[1]),
        .LOW_RST(LOW_RST[1])
    ) u_den1 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_high_i(wr_high[1]),
        .wr_low_i(wr_low[1]),
        .wdata_i(wdata_i),
        .high_o(high_w[1]),
        .low_o(low_w[1]),
        .coef_o(coef_w[1])
    );

    // Denominator two, registers 0x0f and 0x10
    lfx_coef_pair #(
        .HIGH_RST(HIGH_RST[2]),
        .LOW_RST(LOW_RST[2])
    ) u_den2 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_high_i(wr_high[2]),
        .wr_low_i(wr_low[2]),
        .wdata_i(wdata_i),
        .high_o(high_w[2]),
        .low_o(low_w[2]),
        .coef_o(coef_w[2])
    );

    // Denominator four, registers 0x11 and 0x12
    lfx_coef_pair #(
        .HIGH_RST(HIGH_RST[3]),
        .LOW_RST(LOW_RST[3])
    ) u_den4 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_high_i(wr_high[3]),
        .wr_low_i(wr_low[3]),
        .wdata_i(wdata_i),
        .high_o(high_w[3]),
        .low_o(low_w[3]),
        .coef_o(coef_w[3])
    );

    // Denominator five, registers 0x13 and 0x14
    lfx_coef_pair #(
        .HIGH_RST(HIGH_RST[4]),
        .LOW_RST(LOW_RST[4])
    ) u_den5 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_high_i(wr_high[4]),
        .wr_low_i(wr_low[4]),
        .wdata_i(wdata_i),
        .high_o(high_w[4]),
        .low_o(low_w[4]),
        .coef_o(coef_w[4])
    );

    // Read mux; unmapped addresses read as zero
    logic [7:0] rdata_d;
    always_comb begin
        rdata_d = lfx_pkg::UNMAPPED_RD;
        for (int i = 0; i < NCOEF; i++) begin
            if (hit(page_i, addr_i, HIGH_ADDR[i])) begin
                rdata_d = high_w[i]; // R2
            end
            if (hit(page_i, addr_i, LOW_ADDR[i])) begin
                rdata_d = low_w[i]; // R2
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= lfx_pkg::UNMAPPED_RD;
        end else if (rd_en_i) begin
            rdata_o <= rdata_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_o <= 1'h0;
        end else begin
            rvalid_o <= rd_en_i;
        end
    end

    // Outputs registered so the filter sees clean values; one cycle after
    // the byte register, trading a cycle of latency for glitch-free outputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            effects_numerator_five_o <= coef_of(HIGH_RST[0], LOW_RST[0]); // R3
        end else begin
            effects_numerator_five_o <= coef_w[0]; // R9
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            effects_denominator_one_o <= coef_of(HIGH_RST[1], LOW_RST[1]); // R4
        end else begin
            effects_denominator_one_o <= coef_w[1]; // R9
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            effects_denominator_two_o <= coef_of(HIGH_RST[2], LOW_RST[2]); // R5
        end else begin
            effects_denominator_two_o <= coef_w[2]; // R9
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            effects_denominator_four_o <= coef_of(HIGH_RST[3], LOW_RST[3]); // R6
        end else begin
            effects_denominator_four_o <= coef_w[3]; // R9
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            effects_denominator_five_o <= coef_of(HIGH_RST[4], LOW_RST[4]); // R7 R8
        end else begin
            effects_denominator_five_o <= coef_w[4]; // R9
        end
    end
endmodule
`default_nettype wire

// ==== lfx_coef_regs_props.sv ====
// Checker for the effects coefficient bank, watching its top ports only.
// Assumes one clock domain, reads answered next cycle, coefs two edges on.
`timescale 1ns/1ps
`default_nettype none
module lfx_coef_regs_props (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] page_i,
    input wire logic [6:0] addr_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wdata_i,
    input wire logic rd_en_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic signed [15:0] effects_numerator_five_o,
    input wire logic signed [15:0] effects_denominator_one_o,
    input wire logic signed [15:0] effects_denominator_two_o,
    input wire logic signed [15:0] effects_denominator_four_o,
    input wire logic signed [15:0] effects_denominator_five_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic w = wr_en_i && page_i == 8'h01;
    rd_valid_a: assert property (rd_en_i |=> rvalid_o) else $error("read valid missing");
    rv_pulse_a: assert property (!rd_en_i |=> !rvalid_o) else $error("stray read valid");
    rd_unmap_a: assert property (rd_en_i && page_i != 8'h01 |=> rdata_o == 8'h00)
        else $error("other page read not zero");
    num5_high_a: assert property (w && addr_i == 7'h0b |=> ##1
        effects_numerator_five_o[15:8] == $past(wdata_i, 2)) else $error("num5 high");
    num5_low_a: assert property (w && addr_i == 7'h0c |=> ##1
        effects_numerator_five_o[7:0] == $past(wdata_i, 2)) else $error("num5 low");
    den1_high_a: assert property (w && addr_i == 7'h0d |=> ##1
        effects_denominator_one_o[15:8] == $past(wdata_i, 2)) else $error("den1 high");
    den2_low_a: assert property (w && addr_i == 7'h10 |=> ##1
        effects_denominator_two_o[7:0] == $past(wdata_i, 2)) else $error("den2 low");
    den4_high_a: assert property (w && addr_i == 7'h11 |=> ##1
        effects_denominator_four_o[15:8] == $past(wdata_i, 2)) else $error("den4 high");
    den5_hold_a: assert property (!wr_en_i |=> ##1 $stable(effects_denominator_five_o))
        else $error("den5 moved without write");
    cover property (w ##2 1);
    cover property (rd_en_i && page_i != 8'h01);
    cover property (rd_en_i && wr_en_i);
endmodule
bind lfx_coef_regs lfx_coef_regs_props u_props (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .page_i(page_i),
    .addr_i(addr_i),
    .wr_en_i(wr_en_i),
    .wdata_i(wdata_i),
    .rd_en_i(rd_en_i),
    .rdata_o(rdata_o),
    .rvalid_o(rvalid_o),
    .effects_numerator_five_o(effects_numerator_five_o),
    .effects_denominator_one_o(effects_denominator_one_o),
    .effects_denominator_two_o(effects_denominator_two_o),
    .effects_denominator_four_o(effects_denominator_four_o),
    .effects_denominator_five_o(effects_denominator_five_o)
);
`default_nettype wire

// ==== lfx_coef_regs_tb.sv ====
// Self-checking bench for the effects coefficient bank.
// Assumes the bank alone, driven straight at its register port.
`timescale 1ns/1ps
`default_nettype none
module lfx_coef_regs_tb;
    logic clk_i, rst_n_i, wr_en_i, rd_en_i, rvalid_o;
    logic [7:0] page_i, wdata_i, rdata_o;
    logic [6:0] addr_i;
    logic signed [15:0] effects_numerator_five_o, effects_denominator_one_o;
    logic signed [15:0] effects_denominator_two_o, effects_denominator_four_o;
    logic signed [15:0] effects_denominator_five_o;
    logic [15:0] cf [5];
    logic [7:0] rst_v [10] = '{8'h67, 8'h5d, 8'h7d, 8'h83, 8'h84, 8'hee, 8'h7d, 8'h83, 8'h84, 8'hee};
    logic [7:0] sh [10];
    logic [7:0] exp_q [$];
    logic [31:0] lfsr_q;
    int bad_count = 0, checks_done = 0, cyc = 0;
    lfx_coef_regs uut (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .page_i(page_i),
        .addr_i(addr_i),
        .wr_en_i(wr_en_i),
        .wdata_i(wdata_i),
        .rd_en_i(rd_en_i),
        .rdata_o(rdata_o),
        .rvalid_o(rvalid_o),
        .effects_numerator_five_o(effects_numerator_five_o),
        .effects_denominator_one_o(effects_denominator_one_o),
        .effects_denominator_two_o(effects_denominator_two_o),
        .effects_denominator_four_o(effects_denominator_four_o),
        .effects_denominator_five_o(effects_denominator_five_o)
    );
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    assign cf = '{effects_numerator_five_o, effects_denominator_one_o, effects_denominator_two_o,
        effects_denominator_four_o, effects_denominator_five_o};
    always #12.5 clk_i = ~clk_i;
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic close_out;
        if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // All fields move together, one request per edge
    task automatic op(input logic [7:0] pg, input int a, input logic wr, input logic [7:0] d,
        input logic rd, input logic [7:0] e);
        page_i <= pg;
        addr_i <= 7'(a);
        wr_en_i <= wr;
        wdata_i <= d;
        rd_en_i <= rd;
        if (rd) exp_q.push_back(e);
        @(posedge clk_i);
    endtask
    // Monitor at the falling edge so the read pulse has settled
    always @(negedge clk_i) begin
        if (rvalid_o === 1'h1) begin
            if (exp_q.size() == 0) chk("rvalid_extra", 16'h0, 16'h1);
            else chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata_o});
        end
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        clk_i = 0; rst_n_i = 0; page_i = 0; addr_i = 0; wr_en_i = 0; wdata_i = 0; rd_en_i = 0;
        lfsr_q = 32'h701f78ed;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 5; i++) chk("coef_rst", {rst_v[2*i], rst_v[2*i+1]}, cf[i]);
        chk("den2_sign", 16'h1, {15'h0, effects_denominator_two_o < 0});
        for (int i = 0; i < 10; i++) op(8'h01, 11 + i, 0, 8'h00, 1, rst_v[i]);
        // Write and read together: the read must return the old byte
        for (int i = 0; i < 10; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            sh[i] = lfsr_q[7:0];
            op(8'h01, 11 + i, 1, sh[i], 1, rst_v[i]);
        end
        op(8'h00, 11, 1, 8'h5a, 1, 8'h00);
        op(8'h01, 21, 1, 8'h5a, 1, 8'h00);
        for (int i = 0; i < 10; i++) op(8'h01, 11 + i, 0, 8'h00, 1, sh[i]);
        op(8'h00, 0, 0, 8'h00, 0, 8'h00);
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        for (int i = 0; i < 5; i++) chk("coef", {sh[2*i], sh[2*i+1]}, cf[i]);
        // Mid-run reset must restore the byte registers, not only the outputs
        @(posedge clk_i);
        rst_n_i <= 1'h0;
        @(negedge clk_i);
        for (int i = 0; i < 5; i++) chk("coef_mid_rst", {rst_v[2*i], rst_v[2*i+1]}, cf[i]);
        @(posedge clk_i);
        rst_n_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        for (int i = 0; i < 5; i++) chk("coef_rst_bytes", {rst_v[2*i], rst_v[2*i+1]}, cf[i]);
        chk("reads_left", 16'h0, 16'(exp_q.size()));
        close_out();
    end
endmodule
`default_nettype wire
